/* File: logic/flash_boot_pkg.sv */
// timing constants for the flash reset and first-access sequencer.
// assumes a single 100 MHz clock; all intervals are minimums rounded up.
// Notes on behaviour
// - wait 35 us or 300 us after supplies
// - newer part: first access needs fresh select fall
// - newer part: select high 20 ns beforehand
// - reset low 35 us or 200 ns
// - reset rise to select 200 or 50 ns
// - reset fall to select fall 35 us
// - newer part: pulse plus wait covers 35 us
// - newer part: no permanently low select
`default_nettype none
package flash_boot_pkg;
  localparam int unsigned clk_period_ps = 10000;
  // figures in picoseconds as printed
  localparam longint supply_setup_old_ps = 35000000;
  localparam longint supply_setup_new_ps = 300000000;
  localparam longint init_pulse_old_ps = 35000000;
  localparam longint init_pulse_new_ps = 200000;
  localparam longint init_rise_old_ps = 200000;
  localparam longint init_rise_new_ps = 50000;
  localparam longint init_fall_to_select_ps = 35000000;
  localparam longint select_high_before_access_ps = 20000;
  localparam int cnt_w = 16;
  function automatic logic [cnt_w-1:0] cyc(input longint ps);
    longint c;
    c = (ps + clk_period_ps - 1) / clk_period_ps;
    if (c < 1) c = 1;
    return cnt_w'(c);
  endfunction
  localparam logic [cnt_w-1:0] supply_setup_old_cyc = cyc(supply_setup_old_ps);
  localparam logic [cnt_w-1:0] supply_setup_new_cyc = cyc(supply_setup_new_ps);
  localparam logic [cnt_w-1:0] init_pulse_old_cyc = cyc(init_pulse_old_ps);
  localparam logic [cnt_w-1:0] init_pulse_new_cyc = cyc(init_pulse_new_ps);
  localparam logic [cnt_w-1:0] init_rise_old_cyc = cyc(init_rise_old_ps);
  localparam logic [cnt_w-1:0] init_rise_new_cyc = cyc(init_rise_new_ps);
  localparam logic [cnt_w-1:0] init_fall_sel_cyc = cyc(init_fall_to_select_ps);
  localparam logic [cnt_w-1:0] select_high_cyc = cyc(select_high_before_access_ps);
  localparam logic [cnt_w-1:0] cnt_zero = 16'h0000;
  localparam logic [cnt_w-1:0] cnt_one = 16'h0001;
  typedef enum logic [2:0] {
    st_supply = 3'b000,
    st_pulse = 3'b001,
    st_rise = 3'b011,
    st_select_high = 3'b010,
    st_ready = 3'b110
  } seq_e;
endpackage
`default_nettype wire

/* File: logic/interval_timer.sv */
// down counter: load a count, done is high while the count stands at zero.
// assumes load and count come from the same clock domain.
`default_nettype none
module interval_timer
  import flash_boot_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [cnt_w-1:0] count,
  // status
  output logic done
);
  logic [cnt_w-1:0] remain;
  wire [cnt_w-1:0] next_remain = load ? count :
    (remain == cnt_zero) ? cnt_zero : remain - cnt_one;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) remain <= cnt_zero;
    else remain <= next_remain;
  end
  // done reads only the register, never load: the caller decides load from done,
  // and a path back through load would close a combinational loop
  assign done = (remain == cnt_zero);
endmodule
`default_nettype wire

/* File: logic/flash_boot_seq.sv */
// host-side sequencer for flash reset and first access after power-up or warm reset.
// assumes supplies_ok is synchronous and high once both supplies are valid.
`default_nettype none
module flash_boot_seq
  import flash_boot_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration
  input wire logic newer_variant,
  // system side
  input wire logic supplies_ok,
  input wire logic warm_req,
  input wire logic access_req,
  output logic access_ok,
  output logic seq_busy,
  // flash pins
  output logic flash_reset_n,
  output logic flash_select_n,
  output logic flash_read_n
);
  seq_e state, next_state;
  logic [cnt_w-1:0] fall_left;
  logic timer_load;
  logic [cnt_w-1:0] timer_count;
  wire timer_done;
  // low only in the first cycle after reset
  logic armed;

  // variant choice of minimum counts
  wire [cnt_w-1:0] supply_cyc = newer_variant ? supply_setup_new_cyc : supply_setup_old_cyc;
  wire [cnt_w-1:0] pulse_cyc = newer_variant ? init_pulse_new_cyc : init_pulse_old_cyc;
  wire [cnt_w-1:0] rise_cyc = newer_variant ? init_rise_new_cyc : init_rise_old_cyc;
  // reset-fall to select-fall stays pending across the rise wait
  wire fall_met = (fall_left == cnt_zero);
  wire [cnt_w-1:0] next_fall_left = (state == st_supply) ? init_fall_sel_cyc :
    fall_met ? cnt_zero : fall_left - cnt_one;

  interval_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(timer_load),
    .count(timer_count),
    .done(timer_done)
  );

  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_count = cnt_zero;
    case (state)
      st_supply: begin
        // supply setup covers the longer power-up settling
        if (!supplies_ok || !armed) begin
          timer_load = 1'b1;
          timer_count = supply_cyc;
        end else if (timer_done) begin
          next_state = st_pulse;
          timer_load = 1'b1;
          timer_count = pulse_cyc;
        end
      end
      st_pulse: begin
        if (timer_done) begin
          next_state = st_rise;
          timer_load = 1'b1;
          timer_count = rise_cyc;
        end
      end
      st_rise: begin
        // select stays high through reset and after, never tied low
        if (timer_done && fall_met) begin
          next_state = st_select_high;
          timer_load = 1'b1;
          timer_count = select_high_cyc;
        end
      end
      st_select_high: begin
        if (timer_done) next_state = st_ready;
      end
      st_ready: begin
        if (warm_req) begin
          next_state = st_pulse;
          timer_load = 1'b1;
          timer_count = pulse_cyc;
        end
      end
      default: next_state = st_supply;
    endcase
    if (!supplies_ok) begin
      next_state = st_supply;
      timer_load = 1'b1;
      timer_count = supply_cyc;
    end
  end

  wire ready_next = (next_state == st_ready);
  // first access is a fresh select fall from a held-high select
  wire next_select_n = !(ready_next && access_req);
  // reset pin is held low through the supply wait as well as the pulse,
  // so a supply drop always ends in a full pulse before any access
  wire in_reset_next = (next_state == st_supply) || (next_state == st_pulse);
  wire next_reset_n = !in_reset_next;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_supply;
      fall_left <= init_fall_sel_cyc;
      flash_reset_n <= 1'b0;
      flash_select_n <= 1'b1;
      flash_read_n <= 1'b1;
      access_ok <= 1'b0;
      seq_busy <= 1'b1;
    end else begin
      state <= next_state;
      fall_left <= (next_state == st_pulse && state != st_pulse) ? init_fall_sel_cyc :
        next_fall_left;
      flash_reset_n <= next_reset_n;
      flash_select_n <= next_select_n;
      flash_read_n <= next_select_n;
      access_ok <= ready_next;
      seq_busy <= !ready_next;
    end
  end

  // the timer wakes from reset at zero, which reads as done, so one fresh
  // supply load is forced after reset even when supplies_ok is already high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) armed <= 1'b0;
    else armed <= 1'b1;
  end

  // helper counters for the timing checks; each saturates so that a long idle
  // stretch cannot wrap round and pass for a short interval
  logic [cnt_w-1:0] since_fall, low_len, high_len, rise_len, sup_len;
  wire [cnt_w-1:0] cnt_full = {cnt_w{1'b1}};
  wire reset_falls = flash_reset_n && !next_reset_n;
  wire [cnt_w-1:0] next_since_fall = reset_falls ? cnt_zero :
    (since_fall == cnt_full) ? since_fall : since_fall + cnt_one;
  wire [cnt_w-1:0] next_low_len = flash_reset_n ? cnt_zero :
    (low_len == cnt_full) ? low_len : low_len + cnt_one;
  wire [cnt_w-1:0] next_high_len = !flash_select_n ? cnt_zero :
    (high_len == cnt_full) ? high_len : high_len + cnt_one;
  wire [cnt_w-1:0] next_rise_len = !flash_reset_n ? cnt_zero :
    (rise_len == cnt_full) ? rise_len : rise_len + cnt_one;
  wire [cnt_w-1:0] next_sup_len = !supplies_ok ? cnt_zero :
    (sup_len == cnt_full) ? sup_len : sup_len + cnt_one;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_fall <= cnt_zero;
      low_len <= cnt_zero;
      high_len <= cnt_zero;
      rise_len <= cnt_zero;
      sup_len <= cnt_zero;
    end else begin
      since_fall <= next_since_fall;
      low_len <= next_low_len;
      high_len <= next_high_len;
      rise_len <= next_rise_len;
      sup_len <= next_sup_len;
    end
  end

  sequence sel_fall_s;
    $fell(flash_select_n);
  endsequence

  sequence warm_pulse_s;
    !flash_reset_n ##1 !flash_reset_n;
  endsequence

  sequence ready_served_s;
    access_ok && supplies_ok && !warm_req && access_req;
  endsequence

  // select and reset pin update on the same edge as access_ok, so a select
  // fall seen at one edge pairs with access_ok as sampled at that same edge
  pulse_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(flash_reset_n) |-> $past(low_len) >= pulse_cyc)
    else $error("reset pulse too short");
  fall_to_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_fall_s |-> since_fall >= init_fall_sel_cyc)
    else $error("select fell too soon after reset fell");
  rise_to_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_fall_s |-> $past(rise_len) >= rise_cyc)
    else $error("select fell too soon after reset rose");
  select_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_fall_s |-> $past(high_len) >= select_high_cyc)
    else $error("select not high long enough");
  reset_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !flash_reset_n |-> flash_select_n)
    else $error("select low during reset");
  supply_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !supplies_ok |=> !access_ok [*2])
    else $error("access allowed without supplies");
  access_ready_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_fall_s |-> access_ok)
    else $error("access begun before ready");
  warm_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    access_ok && warm_req && supplies_ok |=> warm_pulse_s)
    else $error("warm reset not started");
  busy_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_busy != access_ok)
    else $error("busy and ready disagree");
  supply_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_fall_s |-> $past(sup_len) >= supply_cyc)
    else $error("access begun before supply wait ended");
  reset_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == st_supply || state == st_pulse) |-> !flash_reset_n)
    else $error("reset pin high during reset phase");
  rise_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == st_rise || state == st_select_high) |-> flash_reset_n && flash_select_n)
    else $error("pins wrong during rise wait");
  refuse_access_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !access_req |=> flash_select_n)
    else $error("select low without a request");
  ready_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ready_served_s |=> !flash_select_n)
    else $error("request not served while ready");
  reset_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(flash_reset_n) |-> $past(access_ok) || $past(!supplies_ok))
    else $error("reset pin fell without a cause");
endmodule
`default_nettype wire

/* File: verif/flash_model.sv */
// behavioural flash: judges the host's pin timing at every select fall while reset is high.
// assumes supplies_ok marks both supplies valid; times are in ns.
`default_nettype none
module flash_model (
  // configuration and supplies
  input wire logic newer_variant,
  input wire logic supplies_ok,
  // flash pins
  input wire logic flash_reset_n,
  input wire logic flash_select_n,
  input wire logic flash_read_n,
  // verdict
  output var int viol,
  output var int accesses
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t_sup = 0.0;
  realtime t_rf = 0.0;
  realtime t_rr = 0.0;
  realtime t_sh = 0.0;
  initial begin
    viol = 0;
    accesses = 0;
  end
  always @(posedge supplies_ok) t_sup = $realtime;
  always @(negedge flash_reset_n) t_rf = $realtime;
  always @(posedge flash_select_n or posedge flash_read_n) t_sh = $realtime;
  always @(posedge flash_reset_n) begin
    if ($realtime - t_rf < (newer_variant ? 200.0 : 35000.0)) viol++;
    t_rr = $realtime;
  end
  // a fall while reset is low is not an access
  always @(negedge flash_select_n) begin
    if (flash_reset_n === 1'b1) begin
      if ($realtime - t_sup < (newer_variant ? 300000.0 : 35000.0)) viol++;
      if ($realtime - t_rf < 35000.0) viol++;
      if ($realtime - t_rr < (newer_variant ? 50.0 : 200.0)) viol++;
      if (newer_variant && $realtime - t_sh < 20.0) viol++;
      accesses++;
    end
  end
endmodule
`default_nettype wire

/* File: verif/flash_boot_seq_bench.sv */
// bench for the flash reset sequencer: power-up and warm reset, both variants.
// assumes the flash model flags any timing breach it sees on the pins.
`default_nettype none
module flash_boot_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, newer_variant, supplies_ok, warm_req, access_req;
  logic access_ok, seq_busy, flash_reset_n, flash_select_n, flash_read_n;
  int viol, accesses, errors = 0, checks = 0;
  flash_boot_seq u_flash_boot_seq (.mclk(mclk), .rst_n(rst_n), .newer_variant(newer_variant),
    .supplies_ok(supplies_ok), .warm_req(warm_req), .access_req(access_req),
    .access_ok(access_ok), .seq_busy(seq_busy), .flash_reset_n(flash_reset_n),
    .flash_select_n(flash_select_n), .flash_read_n(flash_read_n));
  flash_model u_flash_model (.newer_variant(newer_variant), .supplies_ok(supplies_ok),
    .flash_reset_n(flash_reset_n), .flash_select_n(flash_select_n),
    .flash_read_n(flash_read_n), .viol(viol), .accesses(accesses));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic check_min(string what, int lo, int got);
    checks++;
    if (got < lo) begin
      errors++;
      $display("unexpected %s: expected at least %0d, seen %0d", what, lo, got);
    end
  endtask
  // access_req stays high, so select must wait for the sequencer by itself
  task automatic wait_ready(output int n);
    n = 0;
    while (access_ok !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (access_ok !== 1'b1) check_bit("select while busy", 1'b1, flash_select_n);
      if (n > 40000) begin
        errors++;
        $display("unexpected wait: expected ready, seen busy");
        close_out();
      end
    end
  endtask
  task automatic first_access(int acc_exp);
    @(posedge mclk);
    #1;
    check_bit("select low", 1'b0, flash_select_n);
    check_bit("read low", 1'b0, flash_read_n);
    check_bit("ready flag", 1'b1, access_ok);
    check_bit("busy flag", 1'b0, seq_busy);
    check_bit("access counted", 1'b1, accesses == acc_exp);
    check_bit("pin timing clean", 1'b1, viol == 0);
  endtask
  task automatic power_up(logic newer, int min_cyc, int acc_exp);
    int n;
    @(posedge mclk);
    supplies_ok <= 1'b0;
    newer_variant <= newer;
    repeat (3) @(posedge mclk);
    supplies_ok <= 1'b1;
    wait_ready(n);
    check_min("supply wait cycles", min_cyc, n);
    first_access(acc_exp);
  endtask
  task automatic warm(int acc_exp);
    int n;
    @(posedge mclk);
    warm_req <= 1'b1;
    @(posedge mclk);
    warm_req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check_bit("reset pin low", 1'b0, flash_reset_n);
    check_bit("select high in reset", 1'b1, flash_select_n);
    check_bit("busy in reset", 1'b1, seq_busy);
    wait_ready(n);
    check_min("warm reset cycles", 3496, n);
    first_access(acc_exp);
  endtask
  // dropping the request parks select high; raising it again gives a fresh fall
  // after select has stood high for three cycles
  task automatic pause_access(int acc_exp);
    @(posedge mclk);
    access_req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check_bit("select parked", 1'b1, flash_select_n);
    check_bit("read parked", 1'b1, flash_read_n);
    @(posedge mclk);
    access_req <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_bit("select again", 1'b0, flash_select_n);
    check_bit("access counted again", 1'b1, accesses == acc_exp);
    check_bit("pin timing clean again", 1'b1, viol == 0);
  endtask
  initial begin
    rst_n = 1'b0;
    newer_variant = 1'b0;
    supplies_ok = 1'b0;
    warm_req = 1'b0;
    access_req = 1'b1;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    power_up(1'b0, 3500, 1);
    pause_access(2);
    warm(3);
    power_up(1'b1, 30000, 4);
    warm(5);
    pause_access(6);
    close_out();
  end
endmodule
`default_nettype wire
